// File: logic/svwd_pkg.sv
// package: timing constants and enumerations for the supervisor watchdog reset block
package svwd_pkg;
  localparam int unsigned CLK_HZ         = 25_000_000;
  // internal oscillator figures, in their own units
  localparam int unsigned RST_TIMEOUT_MS = 200;
  localparam int unsigned WD_FAST_MS     = 100;
  localparam int unsigned WD_SLOW_MS     = 1600;
  localparam int unsigned CE_HOLD_US     = 15;
  localparam int unsigned KICK_PULSE_NS  = 100;
  // derived cycle counts at mclk rate (longest times round down, least times round up)
  localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_FAST_CYC     = WD_FAST_MS * (CLK_HZ / 1000);
  localparam int unsigned WD_SLOW_CYC     = WD_SLOW_MS * (CLK_HZ / 1000);
  localparam int unsigned CE_HOLD_CYC     = (CE_HOLD_US * (CLK_HZ / 1000)) / 1000;
  localparam int unsigned KICK_PULSE_CYC  = (KICK_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // external timebase tick counts
  localparam int unsigned EXT_WD_NORMAL  = 1024;
  localparam int unsigned EXT_WD_FIRST   = 4096;
  localparam int unsigned EXT_RST        = 2048;
  // counter width covers the slow watchdog count
  localparam int unsigned CNT_W          = 26;
  // glitch filter length on comparator inputs
  localparam int unsigned FILT_LEN       = 3;
  // reset value of the filter synchronisers and filter outputs
  localparam logic        SYNC_RST_VAL   = 1'b0;

  // three-level kick decode
  typedef enum logic [1:0] {
    SVWD_KICK_LOW  = 2'h0,
    SVWD_KICK_HIGH = 2'h1,
    SVWD_KICK_MID  = 2'h3
  } svwd_kick_e;

  // reset sequencer states, gray order along the usual path
  typedef enum logic [1:0] {
    SVWD_ST_DOWN = 2'h0,
    SVWD_ST_HOLD = 2'h1,
    SVWD_ST_RUN  = 2'h3
  } svwd_state_e;
endpackage : svwd_pkg

// File: logic/svwd_filt.sv
// module: two-flop synchroniser followed by an agreement glitch filter
`timescale 1ns/1ps
module svwd_filt (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic                           s1;
  logic                           s2;
  logic [svwd_pkg::FILT_LEN-1:0]  hist;

  // first flop feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= svwd_pkg::SYNC_RST_VAL;
      s2 <= svwd_pkg::SYNC_RST_VAL;
    end else begin
      s1 <= din;
      s2 <= s1;
    end
  end

  // output moves only when the history agrees, so a one-cycle glitch never passes
  always_ff @(posedge mclk) begin
    if (rst) begin
      hist <= '0;
      dout <= svwd_pkg::SYNC_RST_VAL;
    end else begin
      hist <= {hist[svwd_pkg::FILT_LEN-2:0], s2};
      if (&{hist, s2})
        dout <= 1'b1;
      else if (~|{hist, s2})
        dout <= 1'b0;
    end
  end
endmodule : svwd_filt

// File: logic/svwd_top.sv
// module: supervisor core, reset sequencer, watchdog and chip-enable gating
`timescale 1ns/1ps
module svwd_top (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic supply_low,
  input  wire logic battery_select,
  input  wire logic powerfail_sense,
  input  wire logic timebase_select,
  input  wire logic timebase_input,
  input  wire logic kick_hi,
  input  wire logic kick_lo,
  input  wire logic ce_in_n,
  output logic      battery_active_flag,
  output logic      undervoltage_flag_n,
  output logic      powerfail_flag_n,
  output logic      watchdog_fault_n,
  output logic      reset_n,
  output logic      reset_hi_out,
  output logic      reset_hi_oe,
  output logic      ce_out_n
);
  localparam int unsigned CW = svwd_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // filtered comparator inputs; the supply filter carries supply good, because the filters
  // reset to zero and the supply must read as low until the comparator proves it good
  logic ok_f;
  logic low_f;
  logic batt_f;
  logic pf_f;

  svwd_filt u_low  (.mclk(mclk), .rst(rst), .din(~supply_low),     .dout(ok_f));
  assign low_f = ~ok_f;
  svwd_filt u_batt (.mclk(mclk), .rst(rst), .din(battery_select),  .dout(batt_f));
  svwd_filt u_pf   (.mclk(mclk), .rst(rst), .din(powerfail_sense), .dout(pf_f));

  // pin inputs through two flops
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_s1 <= 5'h1F;
      pin_s2 <= 5'h1F;
    end else begin
      pin_s1 <= {timebase_select, timebase_input, kick_hi, kick_lo, ce_in_n};
      pin_s2 <= pin_s1;
    end
  end

  logic sel_s;
  logic tb_s;
  logic khi_s;
  logic klo_s;
  logic ce_s;
  assign sel_s = pin_s2[4];
  assign tb_s  = pin_s2[3];
  assign khi_s = pin_s2[2];
  assign klo_s = pin_s2[1];
  assign ce_s  = pin_s2[0];

  ////////////////////////////////////////////////////////////////////////
  // kick decode: both thresholds give the three levels
  svwd_pkg::svwd_kick_e kick;
  always_comb begin
    if (khi_s)
      kick = svwd_pkg::SVWD_KICK_HIGH;
    else if (klo_s)
      kick = svwd_pkg::SVWD_KICK_LOW;
    else
      kick = svwd_pkg::SVWD_KICK_MID;
  end

  svwd_pkg::svwd_kick_e kick_q;
  always_ff @(posedge mclk) begin
    if (rst)
      kick_q <= svwd_pkg::SVWD_KICK_MID;
    else
      kick_q <= kick;
  end

  // any change of decoded level counts as a kick; a 100 ns pulse spans three cycles
  logic kick_edge;
  assign kick_edge = (kick != kick_q);
  logic kick_mid;
  assign kick_mid = (kick == svwd_pkg::SVWD_KICK_MID);

  ////////////////////////////////////////////////////////////////////////
  // external timebase tick on rising edge of synchronised input
  logic tb_q;
  always_ff @(posedge mclk) begin
    if (rst)
      tb_q <= 1'b0;
    else
      tb_q <= tb_s;
  end
  logic ext_mode;
  logic step;
  assign ext_mode = ~sel_s;
  assign step     = ext_mode ? (tb_s & ~tb_q) : 1'b1;

  // period lengths for the selected timebase
  logic [CW-1:0] len_rst;
  logic [CW-1:0] len_wd;
  logic [CW-1:0] len_first;
  always_comb begin
    if (ext_mode) begin
      len_rst   = CW'(svwd_pkg::EXT_RST);
      len_wd    = CW'(svwd_pkg::EXT_WD_NORMAL);
      len_first = CW'(svwd_pkg::EXT_WD_FIRST);
    end else if (!tb_s) begin
      len_rst   = CW'(svwd_pkg::RST_TIMEOUT_CYC);
      len_wd    = CW'(svwd_pkg::WD_FAST_CYC);
      len_first = CW'(svwd_pkg::WD_SLOW_CYC);
    end else begin
      len_rst   = CW'(svwd_pkg::RST_TIMEOUT_CYC);
      len_wd    = CW'(svwd_pkg::WD_SLOW_CYC);
      len_first = CW'(svwd_pkg::WD_SLOW_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencer
  svwd_pkg::svwd_state_e state;
  logic [CW-1:0] rcnt;
  logic          wd_fire;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= svwd_pkg::SVWD_ST_DOWN;
      rcnt  <= '0;
    end else begin
      case (state)
        svwd_pkg::SVWD_ST_DOWN: begin
          rcnt <= '0;
          if (!low_f)
            state <= svwd_pkg::SVWD_ST_HOLD;
        end
        svwd_pkg::SVWD_ST_HOLD: begin
          if (low_f) begin
            state <= svwd_pkg::SVWD_ST_DOWN;
          end else if (step) begin
            if (rcnt + CW'(1) >= len_rst) begin
              state <= svwd_pkg::SVWD_ST_RUN;
              rcnt  <= '0;
            end else begin
              rcnt <= rcnt + CW'(1);
            end
          end
        end
        svwd_pkg::SVWD_ST_RUN: begin
          rcnt <= '0;
          if (low_f)
            state <= svwd_pkg::SVWD_ST_DOWN;
          else if (wd_fire)
            state <= svwd_pkg::SVWD_ST_HOLD;
        end
        default: begin
          state <= svwd_pkg::SVWD_ST_DOWN;
          rcnt  <= '0;
        end
      endcase
    end
  end

  logic in_reset;
  assign in_reset = (state != svwd_pkg::SVWD_ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // watchdog timer; the first period after any reset uses the long length
  logic [CW-1:0] wcnt;
  logic          first;
  assign wd_fire = (state == svwd_pkg::SVWD_ST_RUN) && !kick_mid && !kick_edge && step
                   && (wcnt + CW'(1) >= (first ? len_first : len_wd));

  always_ff @(posedge mclk) begin
    if (rst) begin
      wcnt  <= '0;
      first <= 1'b1;
    end else if (in_reset) begin
      wcnt  <= '0;
      first <= 1'b1;
    end else if (kick_mid) begin
      wcnt <= '0;
    end else if (kick_edge) begin
      wcnt  <= '0;
      first <= 1'b0;
    end else if (step) begin
      wcnt <= wd_fire ? '0 : wcnt + CW'(1);
    end
  end

  // fault flag: set by timeout, released by next transition, floating kick, low supply or battery; a transition wins a tie, since it blocks the timeout
  always_ff @(posedge mclk) begin
    if (rst)
      watchdog_fault_n <= 1'b1;
    else if (wd_fire)
      watchdog_fault_n <= 1'b0;
    else if (kick_mid || low_f || batt_f)
      watchdog_fault_n <= 1'b1;
    else if (kick_edge)
      watchdog_fault_n <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // reset outputs, registered from the sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      reset_n      <= 1'b0;
      reset_hi_out <= 1'b0;
      reset_hi_oe  <= 1'b0;
    end else begin
      reset_n      <= ~in_reset;
      reset_hi_out <= 1'b0;      // open drain only ever pulls low
      reset_hi_oe  <= ~in_reset;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // chip-enable gating with 15 us grace after reset asserts
  logic [CW-1:0] ce_cnt;
  logic          ce_pass;
  logic          in_reset_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      ce_pass    <= 1'b0;
      ce_cnt     <= '0;
      in_reset_q <= 1'b1;
    end else begin
      in_reset_q <= in_reset;
      if (!in_reset) begin
        ce_pass <= 1'b1;
        ce_cnt  <= '0;
      end else if (!in_reset_q) begin
        ce_pass <= ~ce_s;
        ce_cnt  <= '0;
      end else if (ce_pass) begin
        if (ce_s || ce_cnt + CW'(1) >= CW'(svwd_pkg::CE_HOLD_CYC))
          ce_pass <= 1'b0;
        ce_cnt <= ce_cnt + CW'(1);
      end
    end
  end

  // output follows the input only while passing, and outside reset only while supply good
  always_ff @(posedge mclk) begin
    if (rst)
      ce_out_n <= 1'b1;
    else
      ce_out_n <= ce_s | ~ce_pass | (low_f & ~in_reset);
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags, independent of the core
  always_ff @(posedge mclk) begin
    if (rst) begin
      battery_active_flag <= 1'b0;
      undervoltage_flag_n <= 1'b0;
      powerfail_flag_n    <= 1'b1;
    end else begin
      battery_active_flag <= batt_f;
      undervoltage_flag_n <= ~low_f;
      powerfail_flag_n    <= ~pf_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_rst_follows: assert property (@(posedge mclk) disable iff (rst)
    low_f |-> ##2 !reset_n) else $error("reset not low under low supply");
  chk_rst_inverse: assert property (@(posedge mclk) disable iff (rst)
    !reset_hi_out && (reset_hi_oe == reset_n)) else $error("high reset not inverse of low reset");
  chk_fault_fire: assert property (@(posedge mclk) disable iff (rst)
    wd_fire |=> !watchdog_fault_n ##1 !reset_n) else $error("timeout did not fault and reset");
  chk_fault_mid: assert property (@(posedge mclk) disable iff (rst)
    (kick_mid && !wd_fire) |=> watchdog_fault_n) else $error("fault low with kick floating");
  chk_fault_hold: assert property (@(posedge mclk) disable iff (rst)
    (!watchdog_fault_n && !kick_edge && !kick_mid && !low_f && !batt_f) |=> !watchdog_fault_n)
    else $error("fault released without transition");
  chk_ce_block: assert property (@(posedge mclk) disable iff (rst)
    $past(ce_s) |-> ce_out_n) else $error("chip enable passed while input high");
  chk_ce_grace: assert property (@(posedge mclk) disable iff (rst)
    (in_reset && in_reset_q && ce_pass) |-> ce_cnt < CW'(svwd_pkg::CE_HOLD_CYC))
    else $error("chip enable grace too long");
  chk_uv_flag: assert property (@(posedge mclk) disable iff (rst)
    $fell(low_f) |=> undervoltage_flag_n) else $error("undervoltage flag release delayed");
  chk_batt_flag: assert property (@(posedge mclk) disable iff (rst)
    battery_active_flag == $past(batt_f)) else $error("battery flag mismatch");
  chk_first_len: assert property (@(posedge mclk) disable iff (rst)
    (state == svwd_pkg::SVWD_ST_HOLD) |=> first) else $error("first period not armed");
endmodule : svwd_top

// File: sim/svwd_cpu_model.sv
// processor model that services the watchdog kick line
`timescale 1ns/1ps
module svwd_cpu_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reset_n,
  input  wire logic [1:0] mode,
  output logic            kick_hi,
  output logic            kick_lo
);
  logic [7:0] tmr;
  logic       lvl;

  // mode 0 toggles the kick level every 256 cycles, mode 1 holds it, mode 2 floats the line
  // a processor held in reset runs no code, so it cannot kick
  always_ff @(posedge mclk) begin
    if (rst) begin
      tmr <= 8'h00;
      lvl <= 1'b0;
    end else if (reset_n && mode == 2'h0) begin
      tmr <= tmr + 8'h01;
      if (tmr == 8'hFF) lvl <= ~lvl;
    end
  end

  // a floating line sits between the thresholds, so neither comparator trips
  assign kick_hi = (mode != 2'h2) && lvl;
  assign kick_lo = (mode != 2'h2) && !lvl;
endmodule : svwd_cpu_model

// File: sim/testbench.sv
// self-checking bench for the supervisor watchdog reset block
`timescale 1ns/1ps
module testbench;
  logic       mclk = 1'b0;
  logic       rst, supply_low, battery_select, powerfail_sense, timebase_select;
  logic       timebase_input = 1'b0;
  logic       ce_in_n, kick_hi, kick_lo, battery_active_flag;
  logic       undervoltage_flag_n, powerfail_flag_n, watchdog_fault_n, reset_n;
  logic       reset_hi_out, reset_hi_oe, ce_out_n, reset_hi_wire;
  logic [1:0] mode;
  logic [1:0] tb_div = 2'h0;
  int         error_cnt, n_checks, n;

  svwd_top i_dut (.mclk(mclk), .rst(rst), .supply_low(supply_low), .battery_select(battery_select),
    .powerfail_sense(powerfail_sense), .timebase_select(timebase_select), .timebase_input(timebase_input),
    .kick_hi(kick_hi), .kick_lo(kick_lo), .ce_in_n(ce_in_n), .battery_active_flag(battery_active_flag),
    .undervoltage_flag_n(undervoltage_flag_n), .powerfail_flag_n(powerfail_flag_n),
    .watchdog_fault_n(watchdog_fault_n), .reset_n(reset_n), .reset_hi_out(reset_hi_out),
    .reset_hi_oe(reset_hi_oe), .ce_out_n(ce_out_n));
  svwd_cpu_model i_cpu (.mclk(mclk), .rst(rst), .reset_n(reset_n), .mode(mode), .kick_hi(kick_hi),
    .kick_lo(kick_lo));

  // open-drain high reset with its pull-up
  assign reset_hi_wire = reset_hi_oe ? reset_hi_out : 1'b1;

  always #20 mclk = ~mclk;

  // external timebase: one rising tick every four cycles keeps the long counts short
  always @(posedge mclk) begin
    tb_div <= tb_div + 2'h1;
    timebase_input <= tb_div[1];
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask : check

  task automatic check_rng(input string name, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : check_rng

  function automatic logic cur(input int which);
    case (which)
      0: return reset_n;
      1: return watchdog_fault_n;
      2: return ce_out_n;
      default: return undervoltage_flag_n;
    endcase
  endfunction : cur

  // waits on falling edges, where outputs have settled; gives up one past the upper bound
  task automatic wait_chk(input string name, input int which, input logic v, input int lo, input int hi);
    n = 0;
    while (cur(which) !== v && n <= hi) begin
      @(negedge mclk);
      n++;
    end
    check_rng(name, lo, hi, n);
  endtask : wait_chk

  task automatic hold_chk(input string name, input int which, input logic v, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(negedge mclk);
      if (cur(which) !== v) bad++;
    end
    check_rng(name, 0, 0, bad);
  endtask : hold_chk

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    @(negedge mclk);
    check("reset_n", 1'b0, reset_n);
    check("fault_n", 1'b1, watchdog_fault_n);
    check("ce_out_n", 1'b1, ce_out_n);
    check("reset_hi", 1'b1, reset_hi_wire);
  endtask : t_reset

  task automatic t_powerup;
    @(posedge mclk) supply_low <= 1'b0;
    wait_chk("uv_rise", 3, 1'b1, 4, 12);
    wait_chk("reset_rel", 0, 1'b1, 8170, 8240);
    check("reset_hi", 1'b0, reset_hi_wire);
  endtask : t_powerup

  task automatic t_flags;
    @(posedge mclk) battery_select <= 1'b1;
    powerfail_sense <= 1'b1;
    repeat (12) @(negedge mclk);
    check("batt_flag", 1'b1, battery_active_flag);
    check("pf_flag", 1'b0, powerfail_flag_n);
    check("reset_n", 1'b1, reset_n);
    @(posedge mclk) battery_select <= 1'b0;
    powerfail_sense <= 1'b0;
    supply_low <= 1'b1;
    repeat (2) @(posedge mclk);
    supply_low <= 1'b0;
    hold_chk("glitch", 0, 1'b1, 12);
    check("batt_flag", 1'b0, battery_active_flag);
    check("pf_flag", 1'b1, powerfail_flag_n);
  endtask : t_flags

  // kick stopped right after a level change; static kick then repeats resets
  task automatic t_fault;
    @(posedge mclk) ce_in_n <= 1'b0;
    repeat (4) @(negedge mclk);
    check("ce_pass", 1'b0, ce_out_n);
    @(kick_hi);
    @(posedge mclk) mode <= 2'h1;
    wait_chk("wd_fault", 1, 1'b0, 4090, 4140);
    wait_chk("wd_reset", 0, 1'b0, 0, 3);
    wait_chk("ce_hold", 2, 1'b1, 368, 380);
    @(posedge mclk) ce_in_n <= 1'b1;
    wait_chk("rst_len", 0, 1'b1, 7790, 7840);
    check("fault_hold", 1'b0, watchdog_fault_n);
    wait_chk("rst_again", 0, 1'b0, 16370, 16440);
    wait_chk("rst_len2", 0, 1'b1, 8180, 8240);
    @(posedge mclk) mode <= 2'h0;
    wait_chk("fault_clr", 1, 1'b1, 0, 300);
  endtask : t_fault

  task automatic t_supply;
    @(posedge mclk) supply_low <= 1'b1;
    wait_chk("sup_rst", 0, 1'b0, 4, 14);
    check("uv_low", 1'b0, undervoltage_flag_n);
    check("ce_block", 1'b1, ce_out_n);
    @(posedge mclk) supply_low <= 1'b0;
    wait_chk("uv_rel", 3, 1'b1, 4, 12);
    check("reset_n", 1'b0, reset_n);
  endtask : t_supply

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  initial begin
    rst = 1;
    supply_low = 1;
    battery_select = 0;
    powerfail_sense = 0;
    timebase_select = 0;
    ce_in_n = 1;
    mode = 0;
    error_cnt = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_powerup;
    t_flags;
    hold_chk("alive", 0, 1'b1, 6000);
    t_fault;
    @(posedge mclk) mode <= 2'h2;
    hold_chk("mid_fault", 1, 1'b1, 6000);
    check("mid_reset", 1'b1, reset_n);
    @(posedge mclk) mode <= 2'h0;
    t_supply;
    summarize;
  end

  // the whole sequence needs about 2.3 ms
  initial begin
    #4_000_000;
    error_cnt++;
    summarize;
  end
endmodule : testbench
